/* design/sps_defs.svh */
// constants for the serial to parallel polarity shifter
// assumes inclusion by bare name from the package and the design modules
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

// number of register stages
`define SPS_STAGES 32
// index of the first and of the last stage
`define SPS_FIRST_STAGE 0
`define SPS_LAST_STAGE 31
// stage contents after reset
`define SPS_SHIFT_RST 32'h00000000
// remembered shift clock level after reset (high, so no false edge at release)
`define SPS_CLK_PREV_RST 1'h1
// overrun flag after reset
`define SPS_OVERRUN_RST 1'h0
// entries of the bit buffer
`define SPS_BUF_DEPTH 2
// buffer fill count width, its reset value and its full mark
`define SPS_CNT_W 2
`define SPS_CNT_RST 2'h0
`define SPS_CNT_FULL 2'h2
`define SPS_BUF_DATA_RST 2'h0

`endif

/* design/sps_pkg.sv */
// state types of the serial to parallel polarity shifter
// assumes sps_defs.svh on the include path
`include "sps_defs.svh"

package sps_pkg;

    // full state of the top module
    typedef struct packed {
        logic [`SPS_STAGES-1:0] shift;
        logic clk_prev;
        logic overrun;
    } sps_top_state_t;

    // full state of the two-entry bit buffer
    typedef struct packed {
        logic [`SPS_BUF_DEPTH-1:0] data;
        logic [`SPS_CNT_W-1:0] count;
    } sps_buf_state_t;

endpackage

/* design/sps_buf2.sv */
// two-entry one-bit buffer with valid and ready on both sides
// assumes one clock, synchronous active-high reset, and a flush input
`timescale 1ns/100ps
`include "sps_defs.svh"

module sps_buf2 (
    input wire logic clk,
    input wire logic srst,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic in_data,
    output logic in_ready,
    output logic out_valid,
    input wire logic out_ready,
    output logic out_data
);

    sps_pkg::sps_buf_state_t st_q;
    sps_pkg::sps_buf_state_t st_d;
    logic push;
    logic pop;

    // handshake terms; head entry is always slot zero
    assign in_ready = (st_q.count != `SPS_CNT_FULL);
    assign out_valid = (st_q.count != `SPS_CNT_RST);
    assign out_data = st_q.data[0];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // next state: push, pop or both in one cycle
    always_comb begin
        st_d = st_q;
        if (flush) begin
            st_d.count = `SPS_CNT_RST;
        end else begin
            unique case ({push, pop})
                2'h2: begin
                    st_d.data[st_q.count[0]] = in_data;
                    st_d.count = st_q.count + 2'h1;
                end
                2'h1: begin
                    st_d.data[0] = st_q.data[1];
                    st_d.count = st_q.count - 2'h1;
                end
                2'h3: begin
                    if (st_q.count == 2'h1) begin
                        st_d.data[0] = in_data;
                    end else begin
                        st_d.data[0] = st_q.data[1];
                        st_d.data[1] = in_data;
                    end
                end
                2'h0: begin
                    st_d.count = st_q.count;
                end
            endcase
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            st_q.data <= `SPS_BUF_DATA_RST;
            st_q.count <= `SPS_CNT_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // fill level never passes the depth
    a_buf_fill_bound: assert property (@(posedge clk) disable iff (srst)
        st_q.count <= `SPS_CNT_FULL)
        else $error("buffer count above depth");

    // a held word stays at the head while the reader stalls
    a_buf_head_hold: assert property (@(posedge clk) disable iff (srst)
        (out_valid && !out_ready && !flush) |=> (out_valid && $stable(out_data)))
        else $error("buffer head lost under stall");

endmodule

/* design/sps_shifter.sv */
// 32-stage serial-in shift register with true or inverted parallel outputs
// assumes all inputs synchronous to CLK_SYS; the host shift clock is sampled
// and its rising edges detected; one two-entry buffer carries the bits
`timescale 1ns/100ps
`include "sps_defs.svh"

module sps_shifter (
    input wire logic CLK_SYS,
    input wire logic SRST,
    input wire logic SERIAL_IN,
    input wire logic SHIFT_CLK,
    input wire logic MASTER_RST,
    input wire logic POL_SEL,
    input wire logic HOLD,
    output logic [`SPS_STAGES-1:0] PARALLEL_OUTPUTS,
    output logic SERIAL_OUT,
    output logic IN_READY,
    output logic OVERRUN
);

    sps_pkg::sps_top_state_t st_q;
    sps_pkg::sps_top_state_t st_d;
    logic clk_rise;
    logic buf_in_ready;
    logic pop_valid;
    logic pop_ready;
    logic pop_data;
    logic pop;
    logic [`SPS_STAGES-1:0] stage_view;

    // rising edge of the sampled host shift clock
    assign clk_rise = SHIFT_CLK && !st_q.clk_prev;

    // the buffer drains only while the register may shift
    assign pop_ready = !HOLD && !MASTER_RST;
    assign pop = pop_valid && pop_ready;

    // bit buffer between edge capture and the stage register
    sps_buf2 u_buf (
        .clk(CLK_SYS),
        .srst(SRST),
        .flush(MASTER_RST),
        .in_valid(clk_rise),
        .in_data(SERIAL_IN),
        .in_ready(buf_in_ready),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_data)
    );

    // next state of the stage register, edge tracker and overrun flag
    always_comb begin
        st_d = st_q;
        st_d.clk_prev = SHIFT_CLK;
        st_d.overrun = clk_rise && !buf_in_ready && !MASTER_RST;
        if (MASTER_RST) begin
            st_d.shift = `SPS_SHIFT_RST;
        end else if (pop) begin
            st_d.shift = {st_q.shift[`SPS_LAST_STAGE-1:`SPS_FIRST_STAGE], pop_data};
        end
    end

    // state register
    always_ff @(posedge CLK_SYS) begin
        if (SRST) begin
            st_q.shift <= `SPS_SHIFT_RST;
            st_q.clk_prev <= `SPS_CLK_PREV_RST;
            st_q.overrun <= `SPS_OVERRUN_RST;
        end else begin
            st_q <= st_d;
        end
    end

    // master reset masks the stages at once, without waiting for the clock
    assign stage_view = MASTER_RST ? `SPS_SHIFT_RST : st_q.shift;

    // per-stage polarity gate, no clock in the path
    genvar i;
    generate
        for (i = 0; i < `SPS_STAGES; i++) begin : g_pol
            assign PARALLEL_OUTPUTS[i] = stage_view[i] ^ POL_SEL;
        end
    endgenerate

    // chain output: last stage in true form; a next device may hang here
    assign SERIAL_OUT = stage_view[`SPS_LAST_STAGE];

    // upstream ready and lost-edge pulse
    assign IN_READY = buf_in_ready;
    assign OVERRUN = st_q.overrun;

    // a popped bit lands in stage one and the rest move up by one
    a_shift_step: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (pop && !MASTER_RST) |=>
        (st_q.shift == {$past(st_q.shift[`SPS_LAST_STAGE-1:`SPS_FIRST_STAGE]), $past(pop_data)}))
        else $error("shift step wrong");

    // no pop, no reset: stages hold
    a_shift_idle: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (!pop && !MASTER_RST) |=> $stable(st_q.shift))
        else $error("stages moved without a pop");

    // newest bit visible on output one in the following cycle
    a_stage_first: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (pop && !MASTER_RST) ##1 (!MASTER_RST && !POL_SEL) |->
        (PARALLEL_OUTPUTS[`SPS_FIRST_STAGE] == $past(pop_data)))
        else $error("first output not newest bit");

    // reset empties the register and keeps it empty while held
    a_rst_clear: assert property (@(posedge CLK_SYS) disable iff (SRST)
        MASTER_RST [*2] |-> (st_q.shift == `SPS_SHIFT_RST))
        else $error("register not cleared by reset");

    // true form while select is low
    a_pol_true: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (!POL_SEL && !MASTER_RST) |-> (PARALLEL_OUTPUTS == st_q.shift))
        else $error("true form wrong");

    // inverted form while select is high, storage untouched by the select
    a_pol_invert: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (POL_SEL && !MASTER_RST) |-> ((PARALLEL_OUTPUTS ^ st_q.shift) == 32'hffffffff))
        else $error("inverted form wrong");

    // a select change flips every output in the same cycle
    a_pol_flip: assert property (@(posedge CLK_SYS) disable iff (SRST)
        ($changed(POL_SEL) && $stable(st_q.shift) && !MASTER_RST && !$past(MASTER_RST)) |->
        (PARALLEL_OUTPUTS == ~$past(PARALLEL_OUTPUTS)))
        else $error("polarity did not follow select at once");

    // chain output ignores the select
    a_serial_true: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (POL_SEL && !MASTER_RST) |-> (SERIAL_OUT != PARALLEL_OUTPUTS[`SPS_LAST_STAGE]))
        else $error("serial output inverted");

    // after a reset the outputs are all zeros or all ones
    a_rst_view: assert property (@(posedge CLK_SYS) disable iff (SRST)
        $past(MASTER_RST) && !pop |->
        (PARALLEL_OUTPUTS == {`SPS_STAGES{POL_SEL}}))
        else $error("reset image wrong");

    // master reset masks the outputs in the same cycle
    a_rst_mask: assert property (@(posedge CLK_SYS) disable iff (SRST)
        MASTER_RST |-> (PARALLEL_OUTPUTS == {`SPS_STAGES{POL_SEL}}))
        else $error("outputs not masked by reset");

    // master reset forces the chain output low at once
    a_rst_serial: assert property (@(posedge CLK_SYS) disable iff (SRST)
        MASTER_RST |-> !SERIAL_OUT)
        else $error("chain output not masked by reset");

    // master reset empties the bit buffer
    a_rst_flush: assert property (@(posedge CLK_SYS) disable iff (SRST)
        MASTER_RST |=> !pop_valid)
        else $error("buffer kept a bit through reset");

    // one cycle of master reset already clears every stage
    a_rst_clear_next: assert property (@(posedge CLK_SYS) disable iff (SRST)
        MASTER_RST |=> (st_q.shift == `SPS_SHIFT_RST))
        else $error("stages not zero after reset");

    // chain output is the stored last stage whatever the select
    a_serial_last: assert property (@(posedge CLK_SYS) disable iff (SRST)
        !MASTER_RST |-> (SERIAL_OUT == st_q.shift[`SPS_LAST_STAGE]))
        else $error("chain output not last stage");

    // with select low the chain output equals the last output
    a_serial_low: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (!POL_SEL && !MASTER_RST) |-> (SERIAL_OUT == PARALLEL_OUTPUTS[`SPS_LAST_STAGE]))
        else $error("chain output differs in true form");

    // a select change leaves the stored stages alone
    a_pol_storage: assert property (@(posedge CLK_SYS) disable iff (SRST)
        ($changed(POL_SEL) && !$past(pop) && !$past(MASTER_RST)) |-> $stable(st_q.shift))
        else $error("select change altered storage");

    // an accepted shift clock rise is held in the buffer
    a_edge_push: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (clk_rise && IN_READY && !MASTER_RST) |=> pop_valid)
        else $error("accepted rise not buffered");

    // with an empty buffer the sampled bit reaches stage one two cycles later
    a_edge_latency: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (clk_rise && !pop_valid && !HOLD && !MASTER_RST) ##1 (!HOLD && !MASTER_RST) |=>
        (st_q.shift[`SPS_FIRST_STAGE] == $past(SERIAL_IN, 2)))
        else $error("shift latency wrong");

    // a stall keeps the stages still
    a_hold_keep: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (HOLD && !MASTER_RST) |=> $stable(st_q.shift))
        else $error("stages moved under stall");

    // a full buffer frees a slot one cycle after the stall ends
    a_ready_drain: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (!IN_READY && !HOLD && !MASTER_RST) |=> IN_READY)
        else $error("buffer did not drain");

    // a rise into a full buffer raises the lost-edge pulse
    a_overrun_set: assert property (@(posedge CLK_SYS) disable iff (SRST)
        (clk_rise && !buf_in_ready && !MASTER_RST) |=> OVERRUN)
        else $error("lost edge not flagged");

    // the lost-edge pulse has no other cause
    a_overrun_cause: assert property (@(posedge CLK_SYS) disable iff (SRST)
        OVERRUN |-> $past(clk_rise && !buf_in_ready && !MASTER_RST))
        else $error("spurious lost-edge pulse");

    // main scenarios
    c_full_shift: cover property (@(posedge CLK_SYS) disable iff (SRST)
        pop ##1 pop ##1 pop);
    c_pol_toggle: cover property (@(posedge CLK_SYS) disable iff (SRST)
        !POL_SEL ##1 POL_SEL ##1 !POL_SEL);
    c_buf_full: cover property (@(posedge CLK_SYS) disable iff (SRST)
        HOLD && !IN_READY);
    c_reset_run: cover property (@(posedge CLK_SYS) disable iff (SRST)
        MASTER_RST ##1 !MASTER_RST ##[1:20] pop);
    c_overrun_hit: cover property (@(posedge CLK_SYS) disable iff (SRST)
        OVERRUN);

endmodule

/* tb/sps_host.sv */
// host controller model: one shift clock pulse per bit, prompt or slow
// assumes go, din and slow change by non-blocking assignment at the clock edge
`timescale 1ns/100ps
module sps_host (
    input wire logic clk,
    input wire logic srst,
    input wire logic go,
    input wire logic din,
    input wire logic slow,
    output logic shift_clk,
    output logic serial_in,
    output logic busy
);
    logic [1:0] cnt_q;
    // shift clock stands low between bits; released data line shows the inverse
    always_ff @(posedge clk) begin
        if (srst) begin
            shift_clk <= 1'h0;
            serial_in <= 1'h0;
            busy <= 1'h0;
            cnt_q <= 2'h0;
        end else if (!busy) begin
            if (go) begin
                serial_in <= din; // upstream stage of a chain
                shift_clk <= 1'h1;
                busy <= 1'h1;
                cnt_q <= slow ? 2'h3 : 2'h0;
            end
        end else if (cnt_q != 2'h0) begin
            cnt_q <= cnt_q - 2'h1;
        end else if (shift_clk) begin
            shift_clk <= 1'h0;
            cnt_q <= slow ? 2'h3 : 2'h0;
        end else begin
            busy <= 1'h0;
            serial_in <= ~serial_in;
        end
    end
endmodule

/* tb/tb.sv */
// self-checking bench for the polarity shifter with a host model
// assumes the design files compiled first
`timescale 1ns/100ps
module tb;
    typedef struct {string n; logic [31:0] v;} sps_note_t;
    logic CLK_SYS = 1'h0;
    logic SRST = 1'h1;
    logic go = 1'h0;
    logic din = 1'h0;
    logic slow = 1'h0;
    logic MASTER_RST = 1'h0;
    logic POL_SEL = 1'h0;
    logic HOLD = 1'h0;
    logic shift_clk, serial_in, busy, sout, rdy, ovr;
    logic [31:0] par, word, seen;
    logic [7:0] lf = 8'h18;
    int miscompares = 0;
    int compares = 0;
    int ovr_cnt = 0;
    sps_note_t q[$];
    sps_note_t cur;
    always #12.5 CLK_SYS = ~CLK_SYS;
    sps_host host (.clk(CLK_SYS), .srst(SRST), .go(go), .din(din), .slow(slow),
        .shift_clk(shift_clk), .serial_in(serial_in), .busy(busy));
    sps_shifter dut (.CLK_SYS(CLK_SYS), .SRST(SRST), .SERIAL_IN(serial_in), .SHIFT_CLK(shift_clk),
        .MASTER_RST(MASTER_RST), .POL_SEL(POL_SEL), .HOLD(HOLD), .PARALLEL_OUTPUTS(par),
        .SERIAL_OUT(sout), .IN_READY(rdy), .OVERRUN(ovr));
    function automatic logic [7:0] lfsr(input logic [7:0] r);
        return {r[6:0], r[7] ^ r[5] ^ r[4] ^ r[3]};
    endfunction
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic note(input string n, input logic [31:0] v);
        q.push_back('{n, v});
    endtask
    task automatic end_sim();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    // hand one bit to the host and wait, bounded, until it is done
    task automatic send(input logic b, input logic s);
        int k;
        go <= 1'h1;
        din <= b;
        slow <= s;
        tick(1);
        go <= 1'h0;
        k = 0;
        do begin
            tick(1);
            k++;
        end while (busy !== 1'h0 && k < 20);
        if (k >= 20) begin
            miscompares++;
            end_sim();
        end
    endtask
    // watcher: counts overrun pulses, compares every pending note
    always @(negedge CLK_SYS) begin
        if (ovr === 1'h1) ovr_cnt++;
        while (q.size() > 0) begin
            cur = q.pop_front();
            case (cur.n)
                "par": seen = par;
                "sout": seen = {31'h0, sout};
                "rdy": seen = {31'h0, rdy};
                default: seen = ovr_cnt;
            endcase
            chk(cur.n, seen, cur.v);
        end
    end
    // main sequence
    initial begin
        tick(5);
        SRST <= 1'h0;
        tick(1);
        word = 32'h0;
        note("par", word);
        note("rdy", 32'h1);
        for (int i = 0; i < 33; i++) begin
            lf = lfsr(lf);
            send(lf[0], lf[1]);
            word = {word[30:0], lf[0]};
            note("par", word ^ {32{POL_SEL}});
            note("sout", {31'h0, word[31]});
            // keep the select until the notes above are compared
            if (i == 31) begin
                tick(1);
                POL_SEL <= 1'h1;
                note("par", ~word);
            end
        end
        tick(1);
        POL_SEL <= 1'h0;
        HOLD <= 1'h1;
        send(1'h1, 1'h0);
        send(1'h0, 1'h1);
        note("rdy", 32'h0);
        send(1'h1, 1'h0);
        note("ovr", 32'h1);
        HOLD <= 1'h0;
        tick(3);
        word = {word[29:0], 2'h2};
        note("par", word);
        note("rdy", 32'h1);
        tick(1);
        MASTER_RST <= 1'h1;
        tick(1);
        note("par", 32'h0);
        note("sout", 32'h0);
        tick(1);
        POL_SEL <= 1'h1;
        send(1'h1, 1'h0);
        note("par", 32'hffffffff);
        note("ovr", 32'h1);
        tick(1);
        MASTER_RST <= 1'h0;
        POL_SEL <= 1'h0;
        tick(1);
        note("par", 32'h0);
        send(1'h1, 1'h0);
        note("par", 32'h1);
        tick(2);
        end_sim();
    end
endmodule
